// [core/core_start_ctrl.sv]
`timescale 1ns/1ns
module core_start_ctrl #(
    parameter int          CLUSTER_VARIANT = 0,
    parameter logic [11:0] MACHINE_TID_CSR = 12'h0F14,
    parameter logic [11:0] USER_TID_CSR    = 12'h0014
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         sys_rst_i,
    // Static configuration and the fetch go pulse
    input  wire logic                         fetch_go_i,
    input  wire logic [31:0]                  reset_start_ptr_i,
    input  wire logic [31:0]                  debug_entry_vector_i,
    input  wire logic [31:0]                  debug_exception_vector_i,
    input  wire logic [31:0]                  hardware_thread_number_i,
    input  wire logic                         cluster_gate_allow_i,
    // Core events
    input  wire logic                         debug_req_i,
    input  wire logic                         debug_exc_i,
    input  wire logic                         debug_ret_i,
    input  wire logic                         sleep_req_i,
    input  wire logic                         wake_i,
    input  wire logic                         csr_rd_i,
    input  wire logic [11:0]                  csr_addr_i,
    // Core controls
    output logic                              fetch_req_o,
    output start_ctrl_pkg::pc_redirect_t      redirect_o,
    output start_ctrl_pkg::csr_rsp_t          csr_rsp_o,
    output logic                              core_idle_o,
    output logic                              clk_gate_en_o,
    // APB slave
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [7:0]                   paddr_i,
    input  wire logic [31:0]                  pwdata_i,
    output logic                              pready_o,
    output logic [31:0]                       prdata_o,
    output logic                              pslverr_o
);
    import start_ctrl_pkg::*;

    // ****************
    // Core control
    // ****************
    logic         fetch_en_r;
    logic         fetch_en_nxt;
    logic         dbg_mode_r;
    logic         dbg_mode_nxt;
    run_state_t   state_r;
    run_state_t   state_nxt;
    logic         fetch_req_nxt;
    logic         idle_nxt;
    logic         gate_nxt;
    pc_redirect_t redir_nxt;
    csr_rsp_t     csr_nxt;
    logic         sw_go_r;

    function automatic logic is_tid_csr(input logic [11:0] a);
        return (a == MACHINE_TID_CSR) || (a == USER_TID_CSR);
    endfunction

    always_comb begin
        fetch_en_nxt = fetch_en_r | fetch_go_i | sw_go_r;
        dbg_mode_nxt = dbg_mode_r;
        state_nxt    = state_r;
        redir_nxt    = '{valid: 1'b0, target: ZERO_WORD};
        if (!fetch_en_r && fetch_en_nxt) begin
            redir_nxt = '{valid: 1'b1, target: reset_start_ptr_i};
        end else if (fetch_en_r && dbg_mode_r && debug_exc_i) begin
            redir_nxt = '{valid: 1'b1, target: debug_exception_vector_i};
        end else if (fetch_en_r && debug_req_i) begin
            redir_nxt    = '{valid: 1'b1, target: debug_entry_vector_i};
            dbg_mode_nxt = 1'b1;
        end else if (fetch_en_r && debug_ret_i) begin
            dbg_mode_nxt = 1'b0;
        end
        case (state_r)
            RUN_ST: begin
                if (fetch_en_r && sleep_req_i && !wake_i && !debug_req_i) begin
                    state_nxt = SLEEP_ST;
                end
            end
            SLEEP_ST: begin
                if (wake_i || debug_req_i) begin
                    state_nxt = RUN_ST;
                end
            end
            default: state_nxt = RUN_ST;
        endcase
        // Fetch stays gated until the flag sets, and while asleep
        fetch_req_nxt = fetch_en_nxt && (state_nxt == RUN_ST);
        idle_nxt      = (state_nxt == SLEEP_ST);
        // Outside the cluster variant the allow input is never looked at
        gate_nxt = (state_nxt == RUN_ST) ||
                   ((CLUSTER_VARIANT == 1) && cluster_gate_allow_i);
        csr_nxt = '{valid: csr_rd_i, hit: 1'b0, data: ZERO_WORD};
        if (csr_rd_i && is_tid_csr(csr_addr_i)) begin
            csr_nxt.hit  = 1'b1;
            csr_nxt.data = hardware_thread_number_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fetch_en_r    <= 1'b0;
            dbg_mode_r    <= 1'b0;
            state_r       <= RUN_ST;
            fetch_req_o   <= 1'b0;
            core_idle_o   <= 1'b0;
            clk_gate_en_o <= 1'b1;
            redirect_o    <= '0;
            csr_rsp_o     <= '0;
        end else begin
            fetch_en_r    <= fetch_en_nxt;
            dbg_mode_r    <= dbg_mode_nxt;
            state_r       <= state_nxt;
            fetch_req_o   <= fetch_req_nxt;
            core_idle_o   <= idle_nxt;
            clk_gate_en_o <= gate_nxt;
            redirect_o    <= redir_nxt;
            csr_rsp_o     <= csr_nxt;
        end
    end

    // ****************
    // APB slave
    // ****************
    logic        setup;
    logic        pready_nxt;
    logic        pslverr_nxt;
    logic [31:0] prdata_nxt;
    logic        sw_go_nxt;
    logic        sw_go_hold_r;

    // Setup phase alone is decoded; answer is ready for the access cycle
    assign setup = psel_i && !penable_i;

    always_comb begin
        pready_nxt  = setup;
        pslverr_nxt = 1'b0;
        prdata_nxt  = ZERO_WORD;
        sw_go_nxt   = 1'b0;
        if (setup) begin
            if (paddr_i == CTRL_OFS) begin
                prdata_nxt[CTRL_GO_BIT] = fetch_en_r;
                sw_go_nxt = pwrite_i && pwdata_i[CTRL_GO_BIT];
            end else if (paddr_i == STATUS_OFS) begin
                prdata_nxt[STAT_FEN_BIT]  = fetch_en_r;
                prdata_nxt[STAT_IDLE_BIT] = core_idle_o;
                prdata_nxt[STAT_DBG_BIT]  = dbg_mode_r;
            end else if (paddr_i == HARTID_OFS) begin
                prdata_nxt = hardware_thread_number_i;
            end else if (paddr_i == BOOT_OFS) begin
                prdata_nxt = reset_start_ptr_i;
            end else if (paddr_i == DBG_ENT_OFS) begin
                prdata_nxt = debug_entry_vector_i;
            end else if (paddr_i == DBG_EXC_OFS) begin
                prdata_nxt = debug_exception_vector_i;
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    // Software go acts one edge after the access completes
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
            sw_go_r   <= 1'b0;
        end else begin
            pready_o  <= pready_nxt;
            pslverr_o <= pslverr_nxt;
            prdata_o  <= prdata_nxt;
            sw_go_r   <= pready_o && psel_i && penable_i && pwrite_i && sw_go_hold_r;
        end
    end

    // Write intent latched at setup, used at the completing edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sw_go_hold_r <= 1'b0;
        end else begin
            sw_go_hold_r <= sw_go_nxt;
        end
    end

    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_no_early_fetch;
        fetch_req_o |-> fetch_en_r;
    endproperty
    a_no_early_fetch: assert property (p_no_early_fetch) else $error("Fetch before enable");

    property p_go_latch;
        fetch_go_i |=> fetch_en_r;
    endproperty
    a_go_latch: assert property (p_go_latch) else $error("Go not latched");

    property p_go_sticky;
        fetch_en_r |=> fetch_en_r [*3];
    endproperty
    a_go_sticky: assert property (p_go_sticky) else $error("Fetch enable dropped");

    property p_boot_pc;
        $rose(fetch_en_r) |-> redirect_o.valid && redirect_o.target == $past(reset_start_ptr_i);
    endproperty
    a_boot_pc: assert property (p_boot_pc) else $error("Wrong first pc");

    property p_dbg_entry;
        fetch_en_r && debug_req_i && !(dbg_mode_r && debug_exc_i)
        |=> redirect_o.valid && redirect_o.target == $past(debug_entry_vector_i) && dbg_mode_r;
    endproperty
    a_dbg_entry: assert property (p_dbg_entry) else $error("Bad debug entry");

    property p_dbg_exc;
        fetch_en_r && dbg_mode_r && debug_exc_i
        |=> redirect_o.valid && redirect_o.target == $past(debug_exception_vector_i);
    endproperty
    a_dbg_exc: assert property (p_dbg_exc) else $error("Bad debug exception jump");

    property p_tid_read;
        csr_rd_i && is_tid_csr(csr_addr_i)
        |=> csr_rsp_o.valid && csr_rsp_o.hit && csr_rsp_o.data == $past(hardware_thread_number_i);
    endproperty
    a_tid_read: assert property (p_tid_read) else $error("Thread ID mismatch");

    property p_idle_enter;
        state_r == RUN_ST && fetch_en_r && sleep_req_i && !wake_i && !debug_req_i
        |=> core_idle_o && !fetch_req_o;
    endproperty
    a_idle_enter: assert property (p_idle_enter) else $error("Idle not raised");

    property p_idle_leave;
        core_idle_o && wake_i |=> !core_idle_o;
    endproperty
    a_idle_leave: assert property (p_idle_leave) else $error("Idle not dropped");

    property p_gate_plain;
        (CLUSTER_VARIANT != 1) && core_idle_o |-> !clk_gate_en_o;
    endproperty
    a_gate_plain: assert property (p_gate_plain) else $error("Gate allow used");

    property p_no_go_no_fetch;
        !fetch_en_r && !fetch_go_i && !sw_go_r |=> !redirect_o.valid && !fetch_req_o;
    endproperty
    a_no_go_no_fetch: assert property (p_no_go_no_fetch) else $error("Fetch without go");

    property p_tid_miss;
        csr_rd_i && !is_tid_csr(csr_addr_i)
        |=> csr_rsp_o.valid && !csr_rsp_o.hit && csr_rsp_o.data == ZERO_WORD;
    endproperty
    a_tid_miss: assert property (p_tid_miss) else $error("Other CSR answered");

    property p_dbg_ret;
        fetch_en_r && debug_ret_i && !debug_req_i && !(dbg_mode_r && debug_exc_i) |=> !dbg_mode_r;
    endproperty
    a_dbg_ret: assert property (p_dbg_ret) else $error("Debug mode not left");

    property p_apb_ready;
        psel_i && !penable_i |=> pready_o;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("No ready in access cycle");

    property p_sw_go;
        sw_go_r |=> fetch_en_r;
    endproperty
    a_sw_go: assert property (p_sw_go) else $error("Software go not latched");

    property p_sw_boot_seen;
        sw_go_r ##1 redirect_o.valid;
    endproperty
    c_sw_boot_seen: cover property (p_sw_boot_seen);

    property p_tid_hit_seen;
        csr_rd_i ##1 csr_rsp_o.hit;
    endproperty
    c_tid_hit_seen: cover property (p_tid_hit_seen);

    property p_boot_seen;
        $rose(fetch_en_r) ##1 fetch_req_o;
    endproperty
    c_boot_seen: cover property (p_boot_seen);

    property p_dbg_seen;
        debug_req_i ##1 dbg_mode_r ##[1:8] debug_exc_i;
    endproperty
    c_dbg_seen: cover property (p_dbg_seen);

    property p_sleep_seen;
        core_idle_o ##[1:8] !core_idle_o;
    endproperty
    c_sleep_seen: cover property (p_sleep_seen);

endmodule

// [core/start_ctrl_pkg.sv]
// Operation
// - No instruction fetch after reset while the fetch go input stays low; a write of the CTRL go bit also starts fetch.
// - Once enabled, fetching ignores fetch go until the next reset.
// - Debug entry jumps to the debug entry vector; integrator keeps it word-aligned.
// - Exception in debug mode jumps to the debug exception vector as given; integrator keeps it word-aligned.
// - Machine and user thread ID CSR reads return the hardware thread number.
// - Core idle output is high exactly while the core sleeps.
// - Cluster gate allow is used only in the cluster variant; else tied low.
// - First program counter after reset is the reset start pointer.
package start_ctrl_pkg;

    // ****************
    // Register map
    // ****************
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] STATUS_OFS  = 8'h04;
    localparam logic [7:0] HARTID_OFS  = 8'h08;
    localparam logic [7:0] BOOT_OFS    = 8'h0C;
    localparam logic [7:0] DBG_ENT_OFS = 8'h10;
    localparam logic [7:0] DBG_EXC_OFS = 8'h14;

    localparam int CTRL_GO_BIT   = 0;
    localparam int STAT_FEN_BIT  = 0;
    localparam int STAT_IDLE_BIT = 1;
    localparam int STAT_DBG_BIT  = 2;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ****************
    // Types
    // ****************
    typedef enum logic {
        RUN_ST,
        SLEEP_ST
    } run_state_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] target;
    } pc_redirect_t;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic [31:0] data;
    } csr_rsp_t;

endpackage

// [tb/soc_side_model.sv]
`timescale 1ns/1ns
// Far side: static straps and the fetch go driver
module soc_side_model #(
    parameter logic [31:0] START_PTR = 32'h0000_0082,
    parameter logic [31:0] ENTRY_VEC = 32'h0000_1800,
    parameter logic [31:0] EXC_VEC   = 32'h0000_1810,
    parameter logic [31:0] HART_NUM  = 32'h0000_0005
) (
    // Clock
    input  wire logic        clk_i,
    // Straps
    output logic             fetch_go_o,
    output logic [31:0]      start_ptr_o,
    output logic [31:0]      entry_vec_o,
    output logic [31:0]      exc_vec_o,
    output logic [31:0]      hart_o,
    output logic             cluster_allow_o
);
    // Constants, so nothing moves once fetching is enabled
    assign start_ptr_o     = START_PTR;
    assign entry_vec_o     = ENTRY_VEC;
    assign exc_vec_o       = EXC_VEC;
    assign hart_o          = HART_NUM;
    assign cluster_allow_o = 1'b0;
    initial fetch_go_o = 1'b0;
    task automatic go_pulse(input int n);
        @(posedge clk_i);
        fetch_go_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        fetch_go_o <= 1'b0;
    endtask
endmodule

// [tb/tb_core_start_and_debug_vector_ctrl.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t line %0d", $time, `__LINE__); end end
module tb_core_start_and_debug_vector_ctrl;
    import start_ctrl_pkg::*;
    localparam logic [5:0] EV_CSR = 6'h20, EV_DREQ = 6'h10, EV_DEXC = 6'h08, EV_DRET = 6'h04, EV_SLP = 6'h02;
    logic              clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              csr_rd_i = 1'b0, debug_req_i = 1'b0, debug_exc_i = 1'b0, debug_ret_i = 1'b0;
    logic              sleep_req_i = 1'b0, wake_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0]       csr_addr_i = 12'h000;
    logic [7:0]        paddr_i = 8'h00;
    logic [31:0]       pwdata_i = 32'h0000_0000;
    logic              fetch_go, cluster_allow, fetch_req_o, core_idle_o, clk_gate_en_o, pready_o, pslverr_o, rd_e;
    logic [31:0]       start_ptr, entry_vec, exc_vec, hart, prdata_o, rd_q;
    logic [11:0]       csr_tab [3] = '{12'h0F14, 12'h0014, 12'h0300};
    pc_redirect_t      redirect_o;
    csr_rsp_t          csr_rsp_o;
    int                failures = 0;
    int                total_checks = 0;
    int                cycles = 0;

    always #20 clk_i = ~clk_i;

    soc_side_model far_u (.clk_i(clk_i), .fetch_go_o(fetch_go), .start_ptr_o(start_ptr), .entry_vec_o(entry_vec),
        .exc_vec_o(exc_vec), .hart_o(hart), .cluster_allow_o(cluster_allow));

    core_start_ctrl dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .fetch_go_i(fetch_go), .reset_start_ptr_i(start_ptr),
        .debug_entry_vector_i(entry_vec), .debug_exception_vector_i(exc_vec), .hardware_thread_number_i(hart),
        .cluster_gate_allow_i(cluster_allow), .debug_req_i(debug_req_i), .debug_exc_i(debug_exc_i),
        .debug_ret_i(debug_ret_i), .sleep_req_i(sleep_req_i), .wake_i(wake_i), .csr_rd_i(csr_rd_i),
        .csr_addr_i(csr_addr_i), .fetch_req_o(fetch_req_o), .redirect_o(redirect_o), .csr_rsp_o(csr_rsp_o),
        .core_idle_o(core_idle_o), .clk_gate_en_o(clk_gate_en_o), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
        .pslverr_o(pslverr_o));

    task automatic summarize();
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Request held until the edge that samples pready high; data taken there
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd_q = prdata_o;
        rd_e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // One-cycle event pulse, returns where the registered answer is settled
    task automatic fire(input logic [5:0] m, input logic [11:0] a);
        @(posedge clk_i);
        {csr_rd_i, debug_req_i, debug_exc_i, debug_ret_i, sleep_req_i, wake_i} <= m;
        csr_addr_i <= a;
        @(posedge clk_i);
        {csr_rd_i, debug_req_i, debug_exc_i, debug_ret_i, sleep_req_i, wake_i} <= 6'h00;
        @(negedge clk_i);
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        fire(EV_DREQ, 12'h000);
        `CHK({redirect_o.valid, fetch_req_o}, 2'b00)
        apb(1'b0, STATUS_OFS, ZERO_WORD);
        `CHK(rd_q[STAT_FEN_BIT], 1'b0)
        apb(1'b0, 8'h20, ZERO_WORD);
        `CHK({rd_e, rd_q}, {1'b1, ZERO_WORD})
        far_u.go_pulse(1);
        @(negedge clk_i);
        `CHK(redirect_o, {1'b1, start_ptr})
        `CHK(fetch_req_o, 1'b1)
        far_u.go_pulse(2);
        @(negedge clk_i);
        `CHK({redirect_o.valid, fetch_req_o}, 2'b01)
        for (int i = 0; i < 3; i++) begin
            fire(EV_CSR, csr_tab[i]);
            `CHK(csr_rsp_o, {1'b1, i < 2, (i < 2) ? hart : ZERO_WORD})
        end
        fire(EV_DREQ, 12'h000);
        `CHK(redirect_o, {1'b1, entry_vec})
        apb(1'b0, STATUS_OFS, ZERO_WORD);
        `CHK(({rd_q[STAT_DBG_BIT], rd_q[STAT_IDLE_BIT], rd_q[STAT_FEN_BIT]}), 3'b101)
        fire(EV_DEXC, 12'h000);
        `CHK(redirect_o, {1'b1, exc_vec})
        fire(EV_DRET, 12'h000);
        fire(EV_DEXC, 12'h000);
        `CHK(redirect_o.valid, 1'b0)
        fire(EV_SLP, 12'h000);
        `CHK(({core_idle_o, fetch_req_o, clk_gate_en_o}), 3'b100)
        apb(1'b0, STATUS_OFS, ZERO_WORD);
        `CHK(({rd_q[STAT_DBG_BIT], rd_q[STAT_IDLE_BIT], rd_q[STAT_FEN_BIT]}), 3'b011)
        fire(6'h01, 12'h000);
        `CHK({core_idle_o, fetch_req_o, clk_gate_en_o}, 3'b011)
        apb(1'b1, HARTID_OFS, 32'hFFFF_FFFF);
        `CHK(rd_e, 1'b0)
        apb(1'b0, HARTID_OFS, ZERO_WORD);
        `CHK(rd_q, hart)
        apb(1'b0, BOOT_OFS, ZERO_WORD);
        `CHK(rd_q, start_ptr)
        apb(1'b0, DBG_ENT_OFS, ZERO_WORD);
        `CHK(rd_q, entry_vec)
        apb(1'b0, DBG_EXC_OFS, ZERO_WORD);
        `CHK(rd_q, exc_vec)
        // Second reset, then enable through the software go bit
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK(fetch_req_o, 1'b0)
        apb(1'b1, CTRL_OFS, 32'h0000_0001);
        `CHK(rd_e, 1'b0)
        @(negedge clk_i);
        `CHK(redirect_o.valid, 1'b0)
        @(negedge clk_i);
        `CHK(redirect_o, {1'b1, start_ptr})
        `CHK(fetch_req_o, 1'b1)
        apb(1'b0, CTRL_OFS, ZERO_WORD);
        `CHK(rd_q[CTRL_GO_BIT], 1'b1)
        summarize();
    end
endmodule
